// ### logic/dms_defs.svh
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH
// physical address width and the cache-line offset
`define DMS_AW 34
`define DMS_LINE_BITS 6
// channel capacity in 64-byte lines, one more bit than a line index
`define DMS_CAPW 29
// pending request queue
`define DMS_DEPTH 4
`define DMS_IDXW 2
// bank/row split of the channel-local byte address
`define DMS_BANK_LSB 7
`define DMS_BANK_W 3
`define DMS_ROW_LSB 10
`define DMS_ROW_W 16
// least spacing between two commands on one channel, in clocks
`define DMS_CMD_GAP 4
// frequency codes: lower code is the lower frequency
`define DMS_FREQ_W 2
`define DMS_FREQ_RST 2'h0
`endif

// ### logic/dms_pkg.sv
package dms_pkg;
    typedef enum logic [1:0] {
        DMS_MODE_NONE,
        DMS_MODE_SINGLE,
        DMS_MODE_FLEX,
        DMS_MODE_ASYM
    } dms_mode_t;
    typedef enum logic {
        DMS_PD_SLOW,
        DMS_PD_FAST
    } dms_pdexit_t;
endpackage

// ### logic/dms_queue.sv
`include "dms_defs.svh"
// small store of pending channel-local byte addresses; read data registered
module dms_queue (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [`DMS_IDXW-1:0] wr_idx,
    input wire logic [`DMS_AW-1:0] wr_data,
    input wire logic [`DMS_IDXW-1:0] rd_idx,
    output logic [`DMS_AW-1:0] rd_data
);
    typedef struct packed {
        logic [`DMS_DEPTH-1:0][`DMS_AW-1:0] mem;
        logic [`DMS_AW-1:0] rd;
    } dms_q_state_t;
    dms_q_state_t st_r;
    dms_q_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = st_r.mem[rd_idx];
        if (wr_en) begin
            st_nxt.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign rd_data = st_r.rd;
endmodule // dms_queue

// ### logic/dms_sched.sv
`include "dms_defs.svh"
// per-channel picker: same-page hits first, else lowest-numbered pending entry
module dms_sched (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`DMS_DEPTH-1:0] pend,
    input wire logic [`DMS_DEPTH-1:0] hit,
    input wire logic [`DMS_DEPTH-1:0] older_ok,
    output logic pick_vld,
    output logic [`DMS_IDXW-1:0] pick_idx
);
    typedef struct packed {
        logic vld;
        logic [`DMS_IDXW-1:0] idx;
    } dms_s_state_t;
    dms_s_state_t st_r;
    dms_s_state_t st_nxt;
    logic [`DMS_DEPTH-1:0] cand;

    always_comb begin
        st_nxt = '0;
        // all pending entries are looked at in one cycle
        cand = ((pend & hit) != '0) ? (pend & hit) : (pend & older_ok);
        for (int i = `DMS_DEPTH - 1; i >= 0; i--) begin
            if (cand[i]) begin
                st_nxt.vld = 1'b1;
                st_nxt.idx = i[`DMS_IDXW-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    AST_HIT_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
        ((pend & hit) != '0) |-> hit[st_nxt.idx] && pend[st_nxt.idx])
        else $error("open page hit passed over");
    assign pick_vld = st_r.vld;
    assign pick_idx = st_r.idx;
endmodule // dms_sched

// ### logic/dms_top.sv
`include "dms_defs.svh"
//==========================================================================
module dms_top (
    input wire logic clk,
    input wire logic arst_n,
    // population straps: bit 0 farthest slot, bit 1 near slot
    input wire logic [1:0] pop_a,
    input wire logic [1:0] pop_b,
    // capacity per channel in 64-byte lines, from presence-detect data
    input wire logic [`DMS_CAPW-1:0] cap_a,
    input wire logic [`DMS_CAPW-1:0] cap_b,
    input wire logic [1:0][`DMS_FREQ_W-1:0] freq_a,
    input wire logic [1:0][`DMS_FREQ_W-1:0] freq_b,
    input wire logic flex_en,
    input wire logic cfg_load,
    // host request
    input wire logic req_vld,
    input wire logic [`DMS_AW-1:0] req_addr,
    output logic req_rdy,
    // issued requests, one pulse per channel
    output logic iss_a_vld,
    output logic [`DMS_AW-1:0] iss_a_addr,
    output logic iss_b_vld,
    output logic [`DMS_AW-1:0] iss_b_addr,
    output dms_pkg::dms_mode_t mode,
    output logic [`DMS_FREQ_W-1:0] mem_freq,
    output dms_pkg::dms_pdexit_t pd_exit,
    output logic cfg_err
);
    localparam int LB = `DMS_LINE_BITS;
    localparam int D = `DMS_DEPTH;

    typedef struct packed {
        logic [1:0] pa_s1, pa_s2, pb_s1, pb_s2;
        logic fl_s1, fl_s2, ld_s1, ld_s2, ld_d;
        dms_pkg::dms_mode_t mode;
        logic [`DMS_CAPW-1:0] zone;
        logic [`DMS_FREQ_W-1:0] freq;
        dms_pkg::dms_pdexit_t pdx;
        logic err;
        logic [1:0][D-1:0] pend;
        logic [1:0][D-1:0][`DMS_BANK_W+`DMS_ROW_W-1:0] tag;
        logic [1:0][`DMS_BANK_W+`DMS_ROW_W-1:0] open_pg;
        logic [1:0][2:0] gap;
        logic [1:0] iss_v;
        logic [1:0] sent;
        logic [1:0][`DMS_IDXW-1:0] sent_idx;
        logic rdy;
    } dms_state_t;
    dms_state_t st_r;
    dms_state_t st_nxt;

    //==========================================================================
    // address mapping, purely combinational
    logic [`DMS_AW-LB-1:0] line;
    logic map_ch;
    logic [`DMS_AW-1:0] loc_addr;
    logic [`DMS_BANK_W+`DMS_ROW_W-1:0] new_tag;
    logic [`DMS_CAPW-1:0] cap_min;
    logic [`DMS_AW-LB:0] zone2;
    logic [1:0][D-1:0] hit;
    logic [1:0][D-1:0] older;
    logic [1:0] pk_v;
    logic [1:0][`DMS_IDXW-1:0] pk_i;
    logic [1:0][`DMS_AW-1:0] q_rd;
    logic [1:0] wr_en;
    logic [`DMS_IDXW-1:0] free_idx;
    logic free_ok;
    logic [`DMS_AW-LB-1:0] loc_line;
    logic cfg_edge;

    assign line = req_addr[`DMS_AW-1:LB];
    assign cap_min = (cap_a < cap_b) ? cap_a : cap_b;
    assign zone2 = {st_r.zone[`DMS_AW-LB-1:0], 1'b0};
    assign cfg_edge = st_r.ld_s2 && !st_r.ld_d;

    always_comb begin
        map_ch = 1'b0;
        loc_line = line;
        case (st_r.mode)
            dms_pkg::DMS_MODE_SINGLE: begin
                map_ch = (st_r.pb_s2 != 2'h0) && (st_r.pa_s2 == 2'h0);
                loc_line = line;
            end
            dms_pkg::DMS_MODE_FLEX: begin
                if ({1'b0, line} < zone2) begin
                    map_ch = line[0];
                    loc_line = {1'b0, line[`DMS_AW-LB-1:1]};
                end else begin
                    // linear tail lives in the larger channel above the zone
                    map_ch = cap_b > cap_a;
                    loc_line = line - zone2[`DMS_AW-LB-1:0] + st_r.zone[`DMS_AW-LB-1:0];
                end
            end
            dms_pkg::DMS_MODE_ASYM: begin
                if ({1'b0, line} < {1'b0, cap_a[`DMS_AW-LB-1:0]}) begin
                    map_ch = 1'b0;
                    loc_line = line;
                end else begin
                    map_ch = 1'b1;
                    loc_line = line - cap_a[`DMS_AW-LB-1:0];
                end
            end
            default: begin
                map_ch = 1'b0;
                loc_line = line;
            end
        endcase
    end
    assign loc_addr = {loc_line, req_addr[LB-1:0]};
    assign new_tag = loc_addr[`DMS_ROW_LSB+`DMS_ROW_W-1:`DMS_BANK_LSB];

    //==========================================================================
    // free slot and per-channel hit vectors
    always_comb begin
        free_ok = 1'b0;
        free_idx = '0;
        for (int i = D - 1; i >= 0; i--) begin
            if (!st_r.pend[map_ch][i]) begin
                free_ok = 1'b1;
                free_idx = i[`DMS_IDXW-1:0];
            end
        end
    end

    genvar c, e;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            for (e = 0; e < D; e++) begin : g_ent
                assign hit[c][e] = st_r.tag[c][e] == st_r.open_pg[c];
                assign older[c][e] = 1'b1;
            end
            // each channel picks on its own, so a request to the other
            // channel never waits on this one's data
            dms_sched u_sched (
                .clk(clk),
                .arst_n(arst_n),
                .pend(st_r.pend[c] & ~({D{st_r.sent[c]}} &
                      (D'(1) << st_r.sent_idx[c]))),
                .hit(hit[c]),
                .older_ok(older[c]),
                .pick_vld(pk_v[c]),
                .pick_idx(pk_i[c])
            );
            assign wr_en[c] = req_vld && st_r.rdy && free_ok && (map_ch == 1'(c));
            dms_queue u_q (
                .clk(clk),
                .arst_n(arst_n),
                .wr_en(wr_en[c]),
                .wr_idx(free_idx),
                .wr_data(loc_addr),
                .rd_idx(pk_i[c]),
                .rd_data(q_rd[c])
            );
        end
    endgenerate

    //==========================================================================
    // configuration and issue
    always_comb begin
        st_nxt = st_r;
        st_nxt.pa_s1 = pop_a;
        st_nxt.pa_s2 = st_r.pa_s1;
        st_nxt.pb_s1 = pop_b;
        st_nxt.pb_s2 = st_r.pb_s1;
        st_nxt.fl_s1 = flex_en;
        st_nxt.fl_s2 = st_r.fl_s1;
        st_nxt.ld_s1 = cfg_load;
        st_nxt.ld_s2 = st_r.ld_s1;
        st_nxt.ld_d = st_r.ld_s2;
        if (st_r.ld_s2 && !st_r.ld_d) begin
            st_nxt.pend = '0;
            // near slot alone on either channel, or no module on both channels, is a fault
            st_nxt.err = (st_r.pa_s2 == 2'h2) || (st_r.pb_s2 == 2'h2) ||
                         ((st_r.pa_s2 == 2'h0) && (st_r.pb_s2 == 2'h0));
            if ((st_r.pa_s2 != 2'h0) && (st_r.pb_s2 != 2'h0)) begin
                // flex_en or equal capacities give flex, else asymmetric; device type ignored
                if (st_r.fl_s2 || (cap_a == cap_b)) begin
                    st_nxt.mode = dms_pkg::DMS_MODE_FLEX;
                end else begin
                    st_nxt.mode = dms_pkg::DMS_MODE_ASYM;
                end
                st_nxt.zone = cap_min;
            end else if ((st_r.pa_s2 != 2'h0) || (st_r.pb_s2 != 2'h0)) begin
                st_nxt.mode = dms_pkg::DMS_MODE_SINGLE;
                st_nxt.zone = '0;
            end else begin
                st_nxt.mode = dms_pkg::DMS_MODE_NONE;
                st_nxt.zone = '0;
            end
            // lowest frequency code among populated slots
            st_nxt.freq = '1;
            for (int s = 0; s < 2; s++) begin
                if (st_r.pa_s2[s] && freq_a[s] < st_nxt.freq) st_nxt.freq = freq_a[s];
                if (st_r.pb_s2[s] && freq_b[s] < st_nxt.freq) st_nxt.freq = freq_b[s];
            end
            if ((st_r.pa_s2 == 2'h3) || (st_r.pb_s2 == 2'h3)) begin
                st_nxt.pdx = dms_pkg::DMS_PD_FAST;
            end else begin
                st_nxt.pdx = dms_pkg::DMS_PD_SLOW;
            end
        end
        st_nxt.rdy = (st_r.mode != dms_pkg::DMS_MODE_NONE) && !st_r.err;
        for (int k = 0; k < 2; k++) begin
            st_nxt.iss_v[k] = 1'b0;
            st_nxt.sent[k] = 1'b0;
            if (st_r.gap[k] != 3'h0) st_nxt.gap[k] = st_r.gap[k] - 3'h1;
            // one channel's command never waits on the other's
            if (pk_v[k] && st_r.pend[k][pk_i[k]] && (st_r.gap[k] == 3'h0) &&
                !st_r.sent[k]) begin
                st_nxt.iss_v[k] = 1'b1;
                st_nxt.sent[k] = 1'b1;
                st_nxt.sent_idx[k] = pk_i[k];
                st_nxt.pend[k][pk_i[k]] = 1'b0;
                st_nxt.open_pg[k] = st_r.tag[k][pk_i[k]];
                st_nxt.gap[k] = 3'(`DMS_CMD_GAP - 1);
            end
            if (wr_en[k]) begin
                st_nxt.pend[k][free_idx] = 1'b1;
                st_nxt.tag[k][free_idx] = new_tag;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.freq <= `DMS_FREQ_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // queue read data already lines up with iss_v; this extra register makes the address follow iss_v by one clock
    logic [1:0][`DMS_AW-1:0] iss_addr_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            iss_addr_r <= '0;
        end else begin
            iss_addr_r <= q_rd;
        end
    end

    assign req_rdy = st_r.rdy && free_ok;
    assign iss_a_vld = st_r.iss_v[0];
    assign iss_b_vld = st_r.iss_v[1];
    assign iss_a_addr = iss_addr_r[0];
    assign iss_b_addr = iss_addr_r[1];
    assign mode = st_r.mode;
    assign mem_freq = st_r.freq;
    assign pd_exit = st_r.pdx;
    assign cfg_err = st_r.err;

    //==========================================================================
    AST_SPACING: assert property (@(posedge clk) disable iff (!arst_n)
        st_r.iss_v[0] |=> !st_r.iss_v[0] [*3]) else $error("channel a spacing");
    AST_PDX: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r.ld_s2 && !st_r.ld_d && st_r.pa_s2 == 2'h3) |=> st_r.pdx == dms_pkg::DMS_PD_FAST)
        else $error("fast exit not chosen");
    AST_ASYM: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r.ld_s2 && !st_r.ld_d && !st_r.fl_s2 && cap_a != cap_b &&
         st_r.pa_s2 != 2'h0 && st_r.pb_s2 != 2'h0) |=> st_r.mode == dms_pkg::DMS_MODE_ASYM)
        else $error("asymmetric not chosen");
    AST_ILV: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r.mode == dms_pkg::DMS_MODE_FLEX && {1'b0, line} < zone2) |-> map_ch == line[0])
        else $error("interleave channel wrong");

    AST_SPACING_B: assert property (@(posedge clk) disable iff (!arst_n)
        st_r.iss_v[1] |=> !st_r.iss_v[1] [*3]) else $error("channel b spacing");

    //==========================================================================
    // configuration decisions, seen one edge after the load edge
    AST_PDX_SLOW: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_edge && st_r.pa_s2 != 2'h3 && st_r.pb_s2 != 2'h3) |=>
        st_r.pdx == dms_pkg::DMS_PD_SLOW) else $error("slow exit not chosen");

    AST_SYM: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_edge && cap_a == cap_b && st_r.pa_s2 != 2'h0 && st_r.pb_s2 != 2'h0) |=>
        st_r.mode == dms_pkg::DMS_MODE_FLEX) else $error("symmetric not chosen");

    AST_ZONE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_edge && st_r.pa_s2 != 2'h0 && st_r.pb_s2 != 2'h0) |=>
        st_r.zone == $past(cap_min)) else $error("interleave zone size wrong");

    AST_FREQ_A: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_edge && st_r.pa_s2[0]) |=> st_r.freq <= $past(freq_a[0]))
        else $error("frequency above channel a module");

    AST_FREQ_B: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_edge && st_r.pb_s2[0]) |=> st_r.freq <= $past(freq_b[0]))
        else $error("frequency above channel b module");

    AST_NEAR_ALONE: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_edge && (st_r.pa_s2 == 2'h2 || st_r.pb_s2 == 2'h2)) |=> st_r.err)
        else $error("near slot alone not flagged");

    // a fault must close the request port on the following edge
    AST_REFUSE: assert property (@(posedge clk) disable iff (!arst_n)
        st_r.err |=> !st_r.rdy) else $error("ready despite configuration fault");

    //==========================================================================
    // mapping and issue
    // straps are static once loaded, so the live map can be checked
    AST_SINGLE: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r.mode == dms_pkg::DMS_MODE_SINGLE && st_r.pa_s2 != 2'h0 &&
         st_r.pb_s2 == 2'h0) |-> !map_ch) else $error("single channel access misdirected");

    AST_TAIL: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r.mode == dms_pkg::DMS_MODE_FLEX && {1'b0, line} >= zone2) |->
        map_ch == (cap_b > cap_a)) else $error("linear zone channel wrong");

    // the picker may repeat a stale index; the entry must already be retired
    AST_CLEAR_A: assert property (@(posedge clk) disable iff (!arst_n)
        st_r.iss_v[0] |-> !st_r.pend[0][st_r.sent_idx[0]])
        else $error("channel a entry issued twice");

    AST_CLEAR_B: assert property (@(posedge clk) disable iff (!arst_n)
        st_r.iss_v[1] |-> !st_r.pend[1][st_r.sent_idx[1]])
        else $error("channel b entry issued twice");

endmodule // dms_top

// ### sim/dms_dimm_model.sv
`include "dms_defs.svh"
//==========================================================================
// straps and presence-detect data of one channel's unbuffered modules
module dms_dimm_model (
    input wire logic clk,
    input wire logic [1:0] n_mod,
    input wire logic near_only,
    input wire logic [`DMS_CAPW-1:0] lines,
    input wire logic [`DMS_FREQ_W-1:0] spd_lo,
    input wire logic iss_vld,
    input wire logic [`DMS_AW-1:0] iss_addr,
    output logic [1:0] pop,
    output logic [`DMS_CAPW-1:0] cap,
    output logic [1:0][`DMS_FREQ_W-1:0] freq,
    output logic range_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen = 1'b0;
    // one or two slots; the farthest slot fills first unless a fault is asked for
    assign pop = near_only ? 2'h2 : (n_mod == 2'h2 ? 2'h3 : {1'b0, n_mod[0]});
    assign cap = (pop == 2'h0) ? '0 : lines;
    // an empty slot returns all-zero data, the slowest code, to catch a careless minimum
    assign freq[0] = pop[0] ? spd_lo : 2'h0;
    assign freq[1] = pop[1] ? spd_lo + 2'h1 : 2'h0;
    initial range_err = 1'b0;
    always @(posedge clk) begin
        seen <= iss_vld;
        if (seen && (iss_addr >> 6) >= {5'h0, cap}) begin
            range_err <= 1'b1;
        end
    end
endmodule // dms_dimm_model

// ### sim/dual_channel_dram_mapper_scheduler_test.sv
`include "dms_defs.svh"
//==========================================================================
module dual_channel_dram_mapper_scheduler_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic flex_en = 1'b0;
    logic cfg_load = 1'b0;
    logic req_vld = 1'b0;
    logic [`DMS_AW-1:0] req_addr = '0;
    logic [1:0] n_a = 2'h1, n_b = 2'h1;
    logic no_a = 1'b0;
    logic [`DMS_CAPW-1:0] l_a = '0, l_b = '0;
    logic [1:0] s_a = 2'h0, s_b = 2'h0;
    logic [1:0] pop_a, pop_b;
    logic [`DMS_CAPW-1:0] cap_a, cap_b;
    logic [1:0][`DMS_FREQ_W-1:0] freq_a, freq_b;
    logic req_rdy, iss_a_vld, iss_b_vld, cfg_err, re_a, re_b;
    logic [`DMS_AW-1:0] iss_a_addr, iss_b_addr;
    logic [`DMS_FREQ_W-1:0] mem_freq;
    dms_pkg::dms_mode_t mode, cur_mode;
    dms_pkg::dms_pdexit_t pd_exit;
    logic seen_a = 1'b0, seen_b = 1'b0;
    longint q_a[$], q_b[$];
    longint ca, cb;
    int fails = 0, samples_checked = 0, gap_a = 99, gap_b = 99;
    int na[5] = '{1, 2, 2, 1, 1};
    int nb[5] = '{1, 1, 1, 0, 1};
    int la[5] = '{32, 16, 48, 32, 32};
    int lb[5] = '{32, 48, 16, 0, 32};
    int fe[5] = '{0, 1, 0, 0, 0};

    always #12.5 clk = ~clk;

    dms_top u_dms_top (.clk(clk), .arst_n(arst_n), .pop_a(pop_a), .pop_b(pop_b),
        .cap_a(cap_a), .cap_b(cap_b), .freq_a(freq_a), .freq_b(freq_b), .flex_en(flex_en),
        .cfg_load(cfg_load), .req_vld(req_vld), .req_addr(req_addr), .req_rdy(req_rdy),
        .iss_a_vld(iss_a_vld), .iss_a_addr(iss_a_addr), .iss_b_vld(iss_b_vld),
        .iss_b_addr(iss_b_addr), .mode(mode), .mem_freq(mem_freq), .pd_exit(pd_exit),
        .cfg_err(cfg_err));
    dms_dimm_model u_dms_dimm_model_a (.clk(clk), .n_mod(n_a), .near_only(no_a),
        .lines(l_a), .spd_lo(s_a), .iss_vld(iss_a_vld), .iss_addr(iss_a_addr),
        .pop(pop_a), .cap(cap_a), .freq(freq_a), .range_err(re_a));
    dms_dimm_model u_dms_dimm_model_b (.clk(clk), .n_mod(n_b), .near_only(1'b0),
        .lines(l_b), .spd_lo(s_b), .iss_vld(iss_b_vld), .iss_addr(iss_b_addr),
        .pop(pop_b), .cap(cap_b), .freq(freq_b), .range_err(re_b));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reference mapping of a host address to channel and channel-local address
    function automatic longint map_addr(input longint a, output bit ch);
        longint ln, z;
        ln = a >> 6;
        z = (ca < cb) ? ca : cb;
        ch = 1'b0;
        map_addr = a;
        if (cur_mode == dms_pkg::DMS_MODE_SINGLE) begin
            ch = (ca == 0);
        end else if (cur_mode == dms_pkg::DMS_MODE_ASYM && ln >= ca) begin
            ch = 1'b1;
            map_addr = a - ca * 64;
        end else if (cur_mode == dms_pkg::DMS_MODE_FLEX && ln < 2 * z) begin
            ch = ln[0];
            map_addr = ((ln >> 1) << 6) | (a & 63);
        end else if (cur_mode == dms_pkg::DMS_MODE_FLEX) begin
            ch = (cb > ca);
            map_addr = ((ln - z) << 6) | (a & 63);
        end
    endfunction

    // issue spacing and address of every issued request; address follows the pulse by one
    always @(posedge clk) begin
        seen_a <= iss_a_vld;
        seen_b <= iss_b_vld;
        gap_a <= iss_a_vld ? 1 : gap_a + 1;
        gap_b <= iss_b_vld ? 1 : gap_b + 1;
        if (iss_a_vld) check(gap_a >= `DMS_CMD_GAP, 1);
        if (iss_b_vld) check(gap_b >= `DMS_CMD_GAP, 1);
        if (seen_a) check(iss_a_addr, q_a.size() ? q_a.pop_front() : '1);
        if (seen_b) check(iss_b_addr, q_b.size() ? q_b.pop_front() : '1);
    end

    // leaves req_vld high so that a following send runs back to back
    task automatic send(input longint a);
        int n;
        bit ch;
        longint loc;
        n = 0;
        req_vld <= 1'b1;
        req_addr <= a[`DMS_AW-1:0];
        do begin
            @(negedge clk);
            n++;
        end while (req_rdy !== 1'b1 && n < 200);
        if (n >= 200) fails++;
        @(posedge clk);
        loc = map_addr(a, ch);
        if (ch) q_b.push_back(loc);
        else q_a.push_back(loc);
    endtask

    task automatic drain();
        int n;
        req_vld <= 1'b0;
        for (n = 0; n < 100 && (q_a.size() || q_b.size()); n++) @(posedge clk);
        check(q_a.size() + q_b.size(), 0);
        repeat (3) @(posedge clk);
    endtask

    task automatic run_test(input int t);
        logic [1:0] fmin;
        longint a;
        n_a <= na[t];
        n_b <= nb[t];
        no_a <= (t == 4);
        l_a <= la[t];
        l_b <= lb[t];
        s_a <= $urandom_range(3);
        s_b <= $urandom_range(3);
        flex_en <= fe[t];
        cfg_load <= 1'b0;
        repeat (4) @(posedge clk);
        cfg_load <= 1'b1;
        repeat (8) @(posedge clk);
        cfg_load <= 1'b0;
        @(negedge clk);
        ca = la[t];
        cb = lb[t];
        fmin = s_a;
        if (na[t] == 2 && s_a + 2'h1 < fmin) fmin = s_a + 2'h1;
        if (nb[t] > 0 && s_b < fmin) fmin = s_b;
        cur_mode = nb[t] == 0 ? dms_pkg::DMS_MODE_SINGLE :
            (fe[t] || ca == cb) ? dms_pkg::DMS_MODE_FLEX : dms_pkg::DMS_MODE_ASYM;
        check(cfg_err, t == 4);
        if (t == 4) begin
            check(req_rdy, 0);
        end else begin
            check(mode, cur_mode);
            check(mem_freq, fmin);
            check(pd_exit, na[t] == 2 ? dms_pkg::DMS_PD_FAST : dms_pkg::DMS_PD_SLOW);
            @(posedge clk);
            if (t < 2) begin
                a = 64 * 2 * $urandom_range(ca / 2 - 1);
                send(a);
                send(a + 64);
                drain();
            end
            repeat (10) begin
                send($urandom_range((ca + cb) * 64 - 1));
                drain();
            end
        end
        $display("test %0d done", t);
    endtask

    initial begin
        void'($urandom(82));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int t = 0; t < 5; t++) run_test(t);
        check(re_a | re_b, 0);
        give_verdict();
    end

    initial begin
        #(25 * 20000);
        fails++;
        give_verdict();
    end
endmodule // dual_channel_dram_mapper_scheduler_test
